// ---- hw/tms_sequencer.sv ----
// 16-bit timer mode sequencer: normal, clear-on-match and fast pwm
`timescale 1ns/1ps
`default_nettype none

module tms_sequencer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] waveform_mode_select,
  input wire logic [1:0] channel_a_output_action,
  input wire logic [1:0] channel_b_output_action,
  input wire logic [2:0] clock_select,
  input wire logic count_write,
  input wire logic [15:0] count_write_data,
  input wire logic compare_a_write,
  input wire logic compare_b_write,
  input wire logic capture_write,
  input wire logic [15:0] write_data,
  input wire logic [3:0] flag_clear,
  input wire logic [3:0] flag_serviced,
  input wire logic pin_direction_a,
  input wire logic pin_direction_b,
  output logic [15:0] count_value,
  output logic [15:0] compare_a_value,
  output logic [15:0] compare_b_value,
  output logic [15:0] capture_value,
  output logic wrap_flag,
  output logic compare_a_flag,
  output logic compare_b_flag,
  output logic capture_flag,
  output logic wave_output_a,
  output logic wave_output_a_oe,
  output logic wave_output_b,
  output logic wave_output_b_oe,
  output logic dual_slope_mode
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic tms_pkg::tms_class_e mode_class(input logic [3:0] m);
    unique case (m)
      tms_pkg::WM_NORMAL: mode_class = tms_pkg::TMS_CLS_NORMAL;
      tms_pkg::WM_CTC_CMPA, tms_pkg::WM_CTC_CAPT: mode_class = tms_pkg::TMS_CLS_CTC;
      tms_pkg::WM_FPWM_8, tms_pkg::WM_FPWM_9, tms_pkg::WM_FPWM_10,
      tms_pkg::WM_FPWM_CAPT, tms_pkg::WM_FPWM_CMPA: mode_class = tms_pkg::TMS_CLS_FPWM;
      default: mode_class = tms_pkg::TMS_CLS_OTHER;
    endcase
  endfunction : mode_class

  // top value per mode; capture and compare a tops are live registers
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmpa,
                                         input logic [15:0] capt);
    unique case (m)
      tms_pkg::WM_CTC_CMPA, tms_pkg::WM_FPWM_CMPA: top_of = cmpa;
      tms_pkg::WM_CTC_CAPT, tms_pkg::WM_FPWM_CAPT: top_of = capt;
      tms_pkg::WM_FPWM_8: top_of = tms_pkg::TOP_FIX8;
      tms_pkg::WM_FPWM_9: top_of = tms_pkg::TOP_FIX9;
      tms_pkg::WM_FPWM_10: top_of = tms_pkg::TOP_FIX10;
      default: top_of = tms_pkg::CNT_MAX;
    endcase
  endfunction : top_of

  // next output level of one channel from its action and this tick's events
  function automatic logic wave_next(input tms_pkg::tms_class_e cls, input logic [1:0] act,
                                     input logic match, input logic leave_top,
                                     input logic may_toggle, input logic cur);
    wave_next = cur;
    if (cls == tms_pkg::TMS_CLS_FPWM) begin
      // match wins over leaving top so compare equal to top holds a level
      if (act == tms_pkg::ACT_CLEAR) begin
        if (match) wave_next = 1'b1;
        else if (leave_top) wave_next = 1'b0;
      end else if (act == tms_pkg::ACT_SET) begin
        if (match) wave_next = 1'b0;
        else if (leave_top) wave_next = 1'b1;
      end else if (act == tms_pkg::ACT_TOGGLE && may_toggle && match) begin
        wave_next = ~cur;
      end
    end else if (cls != tms_pkg::TMS_CLS_OTHER && match) begin
      unique case (act)
        tms_pkg::ACT_TOGGLE: wave_next = ~cur;
        tms_pkg::ACT_CLEAR: wave_next = 1'b0;
        tms_pkg::ACT_SET: wave_next = 1'b1;
        default: wave_next = cur;
      endcase
    end
  endfunction : wave_next

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  tms_tick_if tk ();
  assign tk.clock_select = clock_select;

  tms_prescaler u_prescaler (
    .clk(clk),
    .nrst(nrst),
    .tk(tk)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] cmpa_q;
  logic [15:0] cmpa_buf_q;
  logic [15:0] cmpb_q;
  logic [15:0] cmpb_buf_q;
  logic [15:0] capt_q;
  logic block_q;
  logic [3:0] flags_q;
  logic [3:0] flags_set;
  logic wave_a_q;
  logic wave_b_q;
  logic pin_a_q;
  logic pin_a_oe_q;
  logic pin_b_q;
  logic pin_b_oe_q;
  logic dual_q;

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  tms_pkg::tms_class_e cls;
  logic [15:0] top_w;
  logic [15:0] wr_masked;
  logic run;
  logic fixed_top;
  logic top_hit;
  logic match_a;
  logic match_b;
  logic wrap_evt;
  logic top_is_capt;
  logic top_is_cmpa;

  // dual-slope codes leave the count untouched here
  assign cls = mode_class(waveform_mode_select);
  assign top_w = top_of(waveform_mode_select, cmpa_q, capt_q);
  assign run = tk.tick && (cls != tms_pkg::TMS_CLS_OTHER);
  assign fixed_top = (waveform_mode_select == tms_pkg::WM_FPWM_8) ||
                     (waveform_mode_select == tms_pkg::WM_FPWM_9) ||
                     (waveform_mode_select == tms_pkg::WM_FPWM_10);
  assign top_is_capt = (waveform_mode_select == tms_pkg::WM_CTC_CAPT) ||
                       (waveform_mode_select == tms_pkg::WM_FPWM_CAPT);
  assign top_is_cmpa = (waveform_mode_select == tms_pkg::WM_CTC_CMPA) ||
                       (waveform_mode_select == tms_pkg::WM_FPWM_CMPA);

  // a blocked tick also skips the top clear, so the count runs on to max
  assign match_a = run && !block_q && (count_q == cmpa_q);
  assign match_b = run && !block_q && (count_q == cmpb_q);
  assign top_hit = run && !block_q && (cls != tms_pkg::TMS_CLS_NORMAL) &&
                   (count_q == top_w);
  assign wrap_evt = (cls == tms_pkg::TMS_CLS_FPWM) ? top_hit :
                    (run && (count_q == tms_pkg::CNT_MAX));
  assign wr_masked = fixed_top ? (write_data & top_w) : write_data;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // a software write wins over the tick in the same cycle
  always_comb begin
    count_d = count_q;
    if (count_write) begin
      count_d = count_write_data;
    end else if (run) begin
      count_d = top_hit ? tms_pkg::CNT_BOTTOM : (count_q + 16'h0001);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_q <= tms_pkg::RST_VALUE;
    end else begin
      count_q <= count_d;
    end
  end

  // match block lasts until the next timer clock, however late it comes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      block_q <= 1'b0;
    end else if (count_write) begin
      block_q <= 1'b1;
    end else if (tk.tick) begin
      block_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // compare and capture registers
  // ----------------------------------------------------------------
  // non-pwm writes go straight through; pwm writes wait in the buffer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmpa_q <= tms_pkg::RST_VALUE;
      cmpa_buf_q <= tms_pkg::RST_VALUE;
    end else begin
      if (compare_a_write) begin
        cmpa_buf_q <= wr_masked;
      end
      if (compare_a_write && (cls == tms_pkg::TMS_CLS_NORMAL || cls == tms_pkg::TMS_CLS_CTC)) begin
        cmpa_q <= wr_masked;
      end else if (top_hit && cls == tms_pkg::TMS_CLS_FPWM) begin
        cmpa_q <= cmpa_buf_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmpb_q <= tms_pkg::RST_VALUE;
      cmpb_buf_q <= tms_pkg::RST_VALUE;
    end else begin
      if (compare_b_write) begin
        cmpb_buf_q <= wr_masked;
      end
      if (compare_b_write && (cls == tms_pkg::TMS_CLS_NORMAL || cls == tms_pkg::TMS_CLS_CTC)) begin
        cmpb_q <= wr_masked;
      end else if (top_hit && cls == tms_pkg::TMS_CLS_FPWM) begin
        cmpb_q <= cmpb_buf_q;
      end
    end
  end

  // capture as top is never buffered
  always_ff @(posedge clk) begin
    if (!nrst) begin
      capt_q <= tms_pkg::RST_VALUE;
    end else if (capture_write) begin
      capt_q <= write_data;
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  always_comb begin
    flags_set = tms_pkg::FLAGS_RST;
    flags_set[tms_pkg::FLG_WRAP] = wrap_evt;
    flags_set[tms_pkg::FLG_CMPA] = match_a || (top_hit && top_is_cmpa);
    flags_set[tms_pkg::FLG_CMPB] = match_b;
    flags_set[tms_pkg::FLG_CAPT] = top_hit && top_is_capt;
  end

  // set wins over a clear or service in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags_q <= tms_pkg::FLAGS_RST;
    end else begin
      flags_q <= (flags_q & ~(flag_clear | flag_serviced)) | flags_set;
    end
  end

  // ----------------------------------------------------------------
  // wave outputs and pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end else begin
      wave_a_q <= wave_next(cls, channel_a_output_action, match_a, top_hit,
                            waveform_mode_select == tms_pkg::WM_FPWM_CMPA, wave_a_q);
      wave_b_q <= wave_next(cls, channel_b_output_action, match_b, top_hit, 1'b0, wave_b_q);
    end
  end

  // pins lag the internal level by one clock; direction gates the drive
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_a_q <= 1'b0;
      pin_a_oe_q <= 1'b0;
      pin_b_q <= 1'b0;
      pin_b_oe_q <= 1'b0;
      dual_q <= 1'b0;
    end else begin
      pin_a_q <= wave_a_q && pin_direction_a;
      pin_a_oe_q <= pin_direction_a;
      pin_b_q <= wave_b_q && pin_direction_b;
      pin_b_oe_q <= pin_direction_b;
      dual_q <= (cls == tms_pkg::TMS_CLS_OTHER);
    end
  end

  assign count_value = count_q;
  assign compare_a_value = cmpa_q;
  assign compare_b_value = cmpb_q;
  assign capture_value = capt_q;
  assign wrap_flag = flags_q[tms_pkg::FLG_WRAP];
  assign compare_a_flag = flags_q[tms_pkg::FLG_CMPA];
  assign compare_b_flag = flags_q[tms_pkg::FLG_CMPB];
  assign capture_flag = flags_q[tms_pkg::FLG_CAPT];
  assign wave_output_a = pin_a_q;
  assign wave_output_a_oe = pin_a_oe_q;
  assign wave_output_b = pin_b_q;
  assign wave_output_b_oe = pin_b_oe_q;
  assign dual_slope_mode = dual_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_normal_rollover:
    assert property (@(posedge clk) disable iff (!nrst)
      (run && cls == tms_pkg::TMS_CLS_NORMAL && count_q == tms_pkg::CNT_MAX && !count_write)
      |=> (count_q == tms_pkg::CNT_BOTTOM) && wrap_flag)
    else $error("normal mode did not roll over with wrap flag");

  a_ctc_top_clear:
    assert property (@(posedge clk) disable iff (!nrst)
      (top_hit && cls == tms_pkg::TMS_CLS_CTC && !count_write)
      |=> (count_q == tms_pkg::CNT_BOTTOM))
    else $error("clear-on-match did not clear at top");

  a_capt_top_flag:
    assert property (@(posedge clk) disable iff (!nrst)
      (top_hit && top_is_capt) |=> capture_flag)
    else $error("capture flag missing at top");

  a_pwm_fixed_top:
    assert property (@(posedge clk) disable iff (!nrst)
      (run && !block_q && waveform_mode_select == tms_pkg::WM_FPWM_9 &&
       count_q == tms_pkg::TOP_FIX9 && !count_write)
      |=> (count_q == tms_pkg::CNT_BOTTOM) && wrap_flag)
    else $error("9-bit fast pwm did not clear at fixed top");

  a_fixed_mask:
    assert property (@(posedge clk) disable iff (!nrst)
      (compare_b_write && fixed_top) |=> ((cmpb_buf_q & ~$past(top_w)) == tms_pkg::CNT_BOTTOM))
    else $error("compare write not masked in fixed top mode");

  a_buffer_load:
    assert property (@(posedge clk) disable iff (!nrst)
      (top_hit && cls == tms_pkg::TMS_CLS_FPWM) |=> (cmpa_q == $past(cmpa_buf_q)) && wrap_flag)
    else $error("compare a buffer not loaded at top");

  a_ctc_toggle:
    assert property (@(posedge clk) disable iff (!nrst)
      (match_a && cls == tms_pkg::TMS_CLS_CTC && channel_a_output_action == tms_pkg::ACT_TOGGLE)
      |=> (wave_a_q != $past(wave_a_q)) ##1
          (pin_a_q == ($past(wave_a_q) && $past(pin_direction_a))))
    else $error("channel a did not toggle on match");

  a_pin_gating:
    assert property (@(posedge clk) disable iff (!nrst)
      !pin_direction_a |=> !wave_output_a && !wave_output_a_oe)
    else $error("pin driven while direction is input");

  a_match_block:
    assert property (@(posedge clk) disable iff (!nrst)
      (count_write ##1 (!count_write && !tk.tick) [*2] ##1 tk.tick)
      |=> !$rose(compare_b_flag))
    else $error("compare match not blocked after count write");

  a_match_flag:
    assert property (@(posedge clk) disable iff (!nrst)
      match_b |=> compare_b_flag)
    else $error("compare b flag not set after match");

  a_wrap_service:
    assert property (@(posedge clk) disable iff (!nrst)
      (flag_serviced[tms_pkg::FLG_WRAP] && !wrap_evt) |=> !wrap_flag)
    else $error("wrap flag not cleared by service");

  a_pwm_noninv:
    assert property (@(posedge clk) disable iff (!nrst)
      (top_hit && !match_a && cls == tms_pkg::TMS_CLS_FPWM &&
       channel_a_output_action == tms_pkg::ACT_CLEAR) |=> !wave_a_q)
    else $error("non-inverting output not cleared leaving top");

endmodule : tms_sequencer
`default_nettype wire

// ---- hw/tms_pkg.sv ----
// constants and types for the 16-bit timer mode sequencer
package tms_pkg;

  // ----------------------------------------------------------------
  // count range and fixed tops
  // ----------------------------------------------------------------
  localparam int CW = 16;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_FIX8 = 16'h00ff;
  localparam logic [15:0] TOP_FIX9 = 16'h01ff;
  localparam logic [15:0] TOP_FIX10 = 16'h03ff;
  localparam logic [15:0] RST_VALUE = 16'h0000;

  // ----------------------------------------------------------------
  // waveform mode codes handled here
  // ----------------------------------------------------------------
  localparam logic [3:0] WM_NORMAL = 4'h0;
  localparam logic [3:0] WM_CTC_CMPA = 4'h4;
  localparam logic [3:0] WM_FPWM_8 = 4'h5;
  localparam logic [3:0] WM_FPWM_9 = 4'h6;
  localparam logic [3:0] WM_FPWM_10 = 4'h7;
  localparam logic [3:0] WM_CTC_CAPT = 4'hc;
  localparam logic [3:0] WM_FPWM_CAPT = 4'he;
  localparam logic [3:0] WM_FPWM_CMPA = 4'hf;

  // ----------------------------------------------------------------
  // output action codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // ----------------------------------------------------------------
  // prescaler selects and divider masks
  // ----------------------------------------------------------------
  localparam logic [2:0] PS_STOP = 3'h0;
  localparam logic [2:0] PS_DIV1 = 3'h1;
  localparam logic [2:0] PS_DIV8 = 3'h2;
  localparam logic [2:0] PS_DIV64 = 3'h3;
  localparam logic [2:0] PS_DIV256 = 3'h4;
  localparam logic [2:0] PS_DIV1024 = 3'h5;
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV64 = 10'h03f;
  localparam logic [9:0] MASK_DIV256 = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
  localparam logic [9:0] DIV_RST = 10'h000;

  // ----------------------------------------------------------------
  // flag vector layout
  // ----------------------------------------------------------------
  localparam int FLAG_W = 4;
  localparam int FLG_WRAP = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAPT = 3;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // mode classes
  typedef enum logic [3:0] {
    TMS_CLS_NORMAL = 4'b0001,
    TMS_CLS_CTC = 4'b0010,
    TMS_CLS_FPWM = 4'b0100,
    TMS_CLS_OTHER = 4'b1000
  } tms_class_e;

endpackage : tms_pkg

// ---- hw/tms_tick_if.sv ----
// carrier between the sequencer and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface tms_tick_if;
  logic [2:0] clock_select;
  logic tick;
  modport pre (input clock_select, output tick);
  modport core (output clock_select, input tick);
endinterface : tms_tick_if
`default_nettype wire

// ---- hw/tms_prescaler.sv ----
// timer clock enable divider for the mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tms_prescaler (
  input wire logic clk,
  input wire logic nrst,
  tms_tick_if.pre tk
);

  // ----------------------------------------------------------------
  // free-running divider
  // ----------------------------------------------------------------
  logic [9:0] div_q;
  logic [9:0] div_d;

  // shared by all taps so a select change never restarts the count
  always_comb begin
    div_d = div_q + 10'h001;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_q <= tms_pkg::DIV_RST;
    end else begin
      div_q <= div_d;
    end
  end

  // one-cycle enable per divided period; unknown selects stop the timer
  always_comb begin
    unique case (tk.clock_select)
      tms_pkg::PS_DIV1: tk.tick = nrst;
      tms_pkg::PS_DIV8: tk.tick = nrst && ((div_q & tms_pkg::MASK_DIV8) == tms_pkg::MASK_DIV8);
      tms_pkg::PS_DIV64: tk.tick = nrst && ((div_q & tms_pkg::MASK_DIV64) == tms_pkg::MASK_DIV64);
      tms_pkg::PS_DIV256: tk.tick = nrst && ((div_q & tms_pkg::MASK_DIV256) == tms_pkg::MASK_DIV256);
      tms_pkg::PS_DIV1024: tk.tick = nrst && (div_q == tms_pkg::MASK_DIV1024);
      default: tk.tick = 1'b0;
    endcase
  end

endmodule : tms_prescaler
`default_nettype wire

// ---- verif/tms_sequencer_bench.sv ----
// self-checking bench for the 16-bit timer mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tms_sequencer_bench;
  typedef struct {logic [3:0] m; logic [15:0] a; logic [15:0] c; logic [15:0] s; int n;
    logic [15:0] e; logic [2:0] f;} tms_row_s;
  logic clk, nrst, count_write, compare_a_write, capture_write, pin_direction_a;
  logic [3:0] waveform_mode_select, flag_clear, flag_serviced;
  logic [1:0] channel_a_output_action;
  logic [2:0] clock_select;
  logic [15:0] count_write_data, write_data, count_value, compare_a_value, exp;
  logic wrap_flag, compare_a_flag, capture_flag, wave_output_a, wave_output_a_oe;
  logic [15:0] compare_b_value, capture_value;
  logic compare_b_flag, wave_output_b, wave_output_b_oe, dual_slope_mode;
  int failures, n_tests, hi, hb, ch;
  int divs [5] = '{1, 8, 64, 256, 1024};
  logic [15:0] duty [3] = '{16'h0000, 16'h0040, 16'h00ff};
  // mode, compare a, capture, start count, ticks, count and {wrap, cmpa, capt} expected
  tms_row_s rows [10] = '{'{4'h0, 16'h0010, 16'h0020, 16'hfffd, 4, 16'h0001, 3'b100},
    '{4'h4, 16'h0003, 16'h0100, 16'h0000, 6, 16'h0002, 3'b010},
    '{4'hc, 16'h0001, 16'h0002, 16'h0000, 5, 16'h0002, 3'b011},
    '{4'h4, 16'h0001, 16'h0100, 16'hfffe, 4, 16'h0000, 3'b110},
    '{4'h5, 16'h0080, 16'h0300, 16'h00fe, 4, 16'h0002, 3'b100},
    '{4'h6, 16'h0080, 16'h0300, 16'h01fe, 3, 16'h0001, 3'b100},
    '{4'h7, 16'h0080, 16'h0300, 16'h03fe, 3, 16'h0001, 3'b100},
    '{4'he, 16'h0003, 16'h0004, 16'h0002, 5, 16'h0002, 3'b111},
    '{4'hf, 16'h0004, 16'h0100, 16'h0002, 5, 16'h0002, 3'b110},
    '{4'h4, 16'h0005, 16'h0100, 16'h0005, 3, 16'h0008, 3'b000}};

  // channel b shares channel a's controls, so both channels track except for toggle in fast pwm with compare a top, which only channel a does
  tms_sequencer tms_sequencer_i (.clk(clk), .nrst(nrst),
    .waveform_mode_select(waveform_mode_select), .channel_a_output_action(channel_a_output_action),
    .channel_b_output_action(channel_a_output_action), .clock_select(clock_select),
    .count_write(count_write), .count_write_data(count_write_data),
    .compare_a_write(compare_a_write), .compare_b_write(compare_a_write),
    .capture_write(capture_write), .write_data(write_data),
    .flag_clear(flag_clear), .flag_serviced(flag_serviced), .pin_direction_a(pin_direction_a),
    .pin_direction_b(pin_direction_a), .count_value(count_value),
    .compare_a_value(compare_a_value), .compare_b_value(compare_b_value),
    .capture_value(capture_value), .wrap_flag(wrap_flag), .compare_a_flag(compare_a_flag),
    .compare_b_flag(compare_b_flag), .capture_flag(capture_flag), .wave_output_a(wave_output_a),
    .wave_output_a_oe(wave_output_a_oe), .wave_output_b(wave_output_b),
    .wave_output_b_oe(wave_output_b_oe), .dual_slope_mode(dual_slope_mode));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic check(string name, logic [15:0] seen, logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, want, seen);
    end
  endtask : check

  // registers loaded with the timer stopped, so no stray match fires
  task automatic setup(logic [3:0] m, logic [15:0] a, logic [15:0] c, logic [15:0] s,
    logic [2:0] sel);
    clock_select = 3'h0;
    waveform_mode_select = 4'h0;
    compare_a_write = 1'b1;
    write_data = a;
    step();
    compare_a_write = 1'b0;
    capture_write = 1'b1;
    write_data = c;
    step();
    capture_write = 1'b0;
    count_write = 1'b1;
    count_write_data = s;
    flag_clear = 4'hf;
    waveform_mode_select = m;
    step();
    count_write = 1'b0;
    flag_clear = 4'h0;
    // started only now, so the old count cannot match under the new mode
    clock_select = sel;
  endtask : setup

  // counts level changes and high cycles of the pin
  task automatic watch(int n);
    logic prev;
    ch = 0;
    hi = 0;
    hb = 0;
    prev = wave_output_a;
    repeat (n) begin
      step();
      ch += int'(wave_output_a !== prev);
      hi += int'(wave_output_a === 1'b1);
      hb += int'(wave_output_b === 1'b1);
      prev = wave_output_a;
    end
  endtask : watch

  task automatic end_of_test();
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // about three times the expected run length
  initial begin
    #500000;
    failures++;
    end_of_test();
  end

  initial begin
    {nrst, count_write, compare_a_write, capture_write, pin_direction_a} = 5'h00;
    {waveform_mode_select, flag_clear, flag_serviced, channel_a_output_action} = 14'h0000;
    {clock_select, count_write_data, write_data} = 35'h000000000;
    repeat (3) step();
    nrst = 1'b1;
    step();
    check("reset", {count_value[13:0], wrap_flag, wave_output_a}, 16'h0000);
    foreach (rows[i]) begin
      setup(rows[i].m, rows[i].a, rows[i].c, rows[i].s, 3'h1);
      repeat (rows[i].n) step();
      check("count_value", count_value, rows[i].e);
      check("flags", {12'h000, wrap_flag, compare_a_flag, capture_flag, compare_b_flag},
            {12'h000, rows[i].f, rows[i].f[1]});
    end
    // wrap flag cleared by interrupt service
    setup(4'h0, 16'h0100, 16'h0100, 16'hffff, 3'h1);
    step();
    check("wrap_flag", {15'h0000, wrap_flag}, 16'h0001);
    flag_serviced = 4'h1;
    step();
    flag_serviced = 4'h0;
    check("wrap_flag", {15'h0000, wrap_flag}, 16'h0000);
    // toggle output in clear-on-match and in fast pwm with compare a top
    channel_a_output_action = 2'h1;
    pin_direction_a = 1'b1;
    setup(4'h4, 16'h0002, 16'h0100, 16'h0000, 3'h1);
    watch(10);
    watch(30);
    check("toggles", 16'(ch), 16'h000a);
    setup(4'hf, 16'h0003, 16'h0100, 16'h0000, 3'h1);
    watch(10);
    watch(40);
    check("toggles", 16'(ch), 16'h000a);
    for (int k = 2; k < 4; k++) begin
      channel_a_output_action = 2'(k);
      setup(4'h4, 16'h0002, 16'h0100, 16'h0000, 3'h1);
      watch(10);
      watch(10);
      check("level", 16'(hi), (k == 3) ? 16'h000a : 16'h0000);
    end
    // duty over one 256-tick period, both polarities
    for (int k = 2; k < 4; k++) begin
      foreach (duty[j]) begin
        channel_a_output_action = 2'(k);
        setup(4'h5, duty[j], 16'h0100, 16'h0000, 3'h1);
        watch(300);
        watch(256);
        exp = (duty[j] == 16'h00ff) ? 16'h0100 : 16'h00ff - duty[j];
        check("high_cycles", 16'(hi), (k == 2) ? exp : 16'h0100 - exp);
        check("high_cycles_b", 16'(hb), (k == 2) ? exp : 16'h0100 - exp);
      end
    end
    // buffered compare write, masked to the fixed resolution
    setup(4'h5, 16'h0040, 16'h0100, 16'h0000, 3'h1);
    compare_a_write = 1'b1;
    write_data = 16'hfff0;
    step();
    compare_a_write = 1'b0;
    step();
    check("compare_a_value", compare_a_value, 16'h0040);
    repeat (260) step();
    check("compare_a_value", compare_a_value, 16'h00f0);
    check("compare_b_value", compare_b_value, 16'h00f0);
    pin_direction_a = 1'b0;
    repeat (2) step();
    check("pin", {12'h000, wave_output_b, wave_output_b_oe, wave_output_a, wave_output_a_oe},
          16'h0000);
    // dual-slope codes freeze the count here
    setup(4'h1, 16'h0010, 16'h0020, 16'h0005, 3'h1);
    repeat (5) step();
    check("count_value", count_value, 16'h0005);
    check("dual_slope_mode", {15'h0000, dual_slope_mode}, 16'h0001);
    check("capture_value", capture_value, 16'h0020);
    // two ticks per prescaler factor, none when stopped
    foreach (divs[j]) begin
      setup(4'h0, 16'h0100, 16'h0100, 16'h0000, 3'(j + 1));
      repeat (2 * divs[j]) step();
      check("count_value", count_value, 16'h0002);
    end
    setup(4'h0, 16'h0100, 16'h0100, 16'h0000, 3'h0);
    repeat (20) step();
    check("count_value", count_value, 16'h0000);
    check("dual_slope_mode", {15'h0000, dual_slope_mode}, 16'h0000);
    end_of_test();
  end
endmodule : tms_sequencer_bench
`default_nettype wire
